// file: design/dau_pkg.sv
// Shared constants and encodings for the data arithmetic datapath
package dau_pkg;

   // ==========================================================
   // Widths
   localparam int ACC_W    = 36;
   localparam int HALF_W   = 16;
   localparam int PROD_W   = 32;
   localparam int ADDR_W   = 16;
   localparam int CNT_W    = 8;
   localparam int GUARD_W  = 4;
   localparam int SIGN_BIT = 31;
   localparam int RND_BIT  = 15;

   // ==========================================================
   // Function statement codes
   localparam logic [3:0] FN_NONE   = 4'h0;
   localparam logic [3:0] FN_P_XY   = 4'h1;
   localparam logic [3:0] FN_LD_P   = 4'h2;
   localparam logic [3:0] FN_ADD_P  = 4'h3;
   localparam logic [3:0] FN_SUB_P  = 4'h4;
   localparam logic [3:0] FN_LD_Y   = 4'h5;
   localparam logic [3:0] FN_ADD_Y  = 4'h6;
   localparam logic [3:0] FN_SUB_Y  = 4'h7;
   localparam logic [3:0] FN_AND_Y  = 4'h8;
   localparam logic [3:0] FN_OR_Y   = 4'h9;
   localparam logic [3:0] FN_XOR_Y  = 4'hA;

   // ==========================================================
   // Transfer statement codes
   localparam logic [3:0] TR_NONE    = 4'h0;
   localparam logic [3:0] TR_Y_X     = 4'h1;
   localparam logic [3:0] TR_YA_X    = 4'h2;
   localparam logic [3:0] TR_Y_LD    = 4'h3;
   localparam logic [3:0] TR_A_LD    = 4'h4;
   localparam logic [3:0] TR_X_LD    = 4'h5;
   localparam logic [3:0] TR_Y_RD    = 4'h6;
   localparam logic [3:0] TR_ST_Y    = 4'h7;
   localparam logic [3:0] TR_ST_A    = 4'h8;
   localparam logic [3:0] TR_Z_YX    = 4'h9;
   localparam logic [3:0] TR_Z_Y     = 4'hA;
   localparam logic [3:0] TR_Z_A     = 4'hB;

   // ==========================================================
   // Special function codes
   localparam logic [3:0] SF_SHR     = 4'h0;
   localparam logic [3:0] SF_SHL     = 4'h1;
   localparam logic [3:0] SF_COPY    = 4'h2;
   localparam logic [3:0] SF_NEG     = 4'h3;
   localparam logic [3:0] SF_INV     = 4'h4;
   localparam logic [3:0] SF_RND     = 4'h5;
   localparam logic [3:0] SF_INCH    = 4'h6;
   localparam logic [3:0] SF_INC     = 4'h7;
   localparam logic [3:0] SF_LD_Y    = 4'h8;
   localparam logic [3:0] SF_LD_P    = 4'h9;

   // ==========================================================
   // Condition codes
   localparam logic [4:0] CC_MI    = 5'h00;
   localparam logic [4:0] CC_PL    = 5'h01;
   localparam logic [4:0] CC_EQ    = 5'h02;
   localparam logic [4:0] CC_NE    = 5'h03;
   localparam logic [4:0] CC_GT    = 5'h04;
   localparam logic [4:0] CC_LE    = 5'h05;
   localparam logic [4:0] CC_LVS   = 5'h06;
   localparam logic [4:0] CC_LVC   = 5'h07;
   localparam logic [4:0] CC_MVS   = 5'h08;
   localparam logic [4:0] CC_MVC   = 5'h09;
   localparam logic [4:0] CC_C0GE  = 5'h0A;
   localparam logic [4:0] CC_C0LT  = 5'h0B;
   localparam logic [4:0] CC_C1GE  = 5'h0C;
   localparam logic [4:0] CC_C1LT  = 5'h0D;
   localparam logic [4:0] CC_HEADS = 5'h0E;
   localparam logic [4:0] CC_TAILS = 5'h0F;
   localparam logic [4:0] CC_TRUE  = 5'h10;
   localparam logic [4:0] CC_FALSE = 5'h11;
   localparam logic [4:0] CC_ALLT  = 5'h12;
   localparam logic [4:0] CC_ALLF  = 5'h13;
   localparam logic [4:0] CC_SOMET = 5'h14;
   localparam logic [4:0] CC_SOMEF = 5'h15;
   localparam logic [4:0] CC_ODDP  = 5'h16;
   localparam logic [4:0] CC_EVENP = 5'h17;
   localparam logic [4:0] CC_MNS1  = 5'h18;
   localparam logic [4:0] CC_NMNS1 = 5'h19;
   localparam logic [4:0] CC_NPINT = 5'h1A;
   localparam logic [4:0] CC_NJINT = 5'h1B;
   localparam logic [4:0] CC_LOCK  = 5'h1C;

   // External flag vector bit positions
   localparam int XF_ALLT  = 0;
   localparam int XF_SOMET = 1;
   localparam int XF_ODDP  = 2;
   localparam int XF_MNS1  = 3;
   localparam int XF_NPINT = 4;
   localparam int XF_NJINT = 5;
   localparam int XF_LOCK  = 6;
   localparam int XF_HEADS = 7;

   // ==========================================================
   // Reset values and timing
   localparam logic [1:0]  CLR_RST   = 2'h0;
   localparam logic [35:0] ACC_RST   = 36'h0;
   localparam logic [7:0]  CNT_RST   = 8'h00;
   localparam logic [3:0]  CYC_BASE  = 4'h1;
   localparam logic [3:0]  CYC_TWO   = 4'h2;

   // Controller states
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_WAIT = 1'b1
   } ctl_state_e;

endpackage

// file: design/mac_alu_special_functions.sv
// Multiply/ALU and special function datapath of the signal processor core
`timescale 1ns/1ps
// Overview of operation
// - Low-half qualifier moves only low 16 bits
// - External X/Y transfer adds programmed wait-states
// - Same-bank internal X and Y access adds one cycle
// - High-half load clears low half unless bit set
// - Reset clears all clear-low control bits
// - X pointer post-modified by +1 or increment
// - Y pointer post-modified by 0,+1,-1,increment
// - Compound addressing modifies Y pointer twice
// - Special functions complete in one cycle
// - External program fetch adds wait-states to special functions
// - Sign-preserving right shifts by 1,4,8,16
// - Left shifts on low 32, guards from bit31
// - Copy, negate and invert accumulator
// - Round source to upper 20 bits
// - High-half increment and full increment
// - Loads from y or product sign-extend
// - Special functions suppressed when condition false
// - Event form counts first, copies on true
// - Function and transfer combine or stand alone
// - Product is x times y, 32 bits
// - Logical and mathematical overflow flags
// - Counter test increments that counter
module mac_alu_special_functions
   import dau_pkg::*;
#(
   parameter int WAIT_W = 4            // Width of wait-state count
)(
   input  wire logic              clk_sys,      // Processor clock
   input  wire logic              nrst,         // Sync reset, active low
   input  wire logic              issue,        // New instruction valid
   input  wire logic              is_special,   // Special function form
   input  wire logic [3:0]        func_code,    // Function statement
   input  wire logic [3:0]        xfer_code,    // Transfer statement
   input  wire logic [3:0]        sf_code,      // Special function code
   input  wire logic [1:0]        shift_sel,    // 0:1 1:4 2:8 3:16
   input  wire logic              dst_sel,      // Destination accumulator
   input  wire logic              src_sel,      // Source accumulator
   input  wire logic              xfer_acc_sel, // Transfer accumulator
   input  wire logic              low_half,     // Low-half qualifier
   input  wire logic              cond_en,      // Conditional form
   input  wire logic              event_cnt,    // Event-counted form
   input  wire logic [4:0]        condition_code, // Tested condition
   input  wire logic [7:0]        ext_flags,    // BIO, BMU, PLL flags
   input  wire logic              x_inc_sel,    // X post-mod by increment
   input  wire logic [1:0]        y_ptr_sel,    // Y pointer select
   input  wire logic [1:0]        y_mod_sel,    // Y post-mod choice
   input  wire logic [15:0]       x_incr,       // X increment register
   input  wire logic [15:0]       y_incr,       // Y increment register
   input  wire logic [15:0]       z_incr,       // Compound increment
   input  wire logic              from_cache,   // Executing from cache
   input  wire logic              x_ext,        // X access is external
   input  wire logic              y_ext,        // Y access is external
   input  wire logic              pc_ext,       // PC is external
   input  wire logic              same_bank,    // X and Y in same bank
   input  wire logic [WAIT_W-1:0] wait_states,  // Programmed wait-states
   input  wire logic [15:0]       x_rdata,      // X-space read data
   input  wire logic [15:0]       y_rdata,      // Y-space read data
   input  wire logic [1:0]        clr_wdata,    // Clear-low bits value
   input  wire logic              clr_we,       // Clear-low bits write
   output logic                   busy,         // Instruction stretching
   output logic [35:0]            accumulator_zero, // Accumulator 0
   output logic [35:0]            accumulator_one,  // Accumulator 1
   output logic [31:0]            prod_out,     // Product register
   output logic [31:0]            y_out,        // y register
   output logic [15:0]            x_out,        // x register
   output logic [15:0]            x_space_pointer, // X pointer
   output logic [15:0]            y_ptr0,       // Y pointer 0
   output logic [15:0]            y_ptr1,       // Y pointer 1
   output logic [15:0]            y_ptr2,       // Y pointer 2
   output logic [15:0]            y_ptr3,       // Y pointer 3
   output logic [15:0]            y_wdata,      // Y-space write data
   output logic                   y_we,         // Y-space write strobe
   output logic [7:0]             event_counter_first, // Event counter
   output logic [7:0]             event_counter_copy,  // Copied counter
   output logic [7:0]             counter0,     // Counter 0
   output logic [1:0]             clear_low_on_load_bits, // Clear-low
   output logic                   lovf,         // Logical overflow
   output logic                   movf          // Mathematical overflow
);

   // ==========================================================
   // Helpers
   function automatic logic [35:0] sx32(input logic [31:0] v);
      sx32 = {{GUARD_W{v[31]}}, v};
   endfunction

   function automatic logic [15:0] pmod(input logic [15:0] p,
                                        input logic [1:0] s,
                                        input logic [15:0] inc,
                                        input logic second);
      // First pass 0,+1,-1,inc; second pass +1,0,+2,inc
      case ({second, s})
         3'h0, 3'h5: pmod = p;
         3'h1, 3'h4: pmod = p + 16'h0001;
         3'h2: pmod = p - 16'h0001;
         3'h6: pmod = p + 16'h0002;
         default: pmod = p + inc;
      endcase
   endfunction

   // ==========================================================
   // State
   logic [35:0] acc_reg [2];
   logic [31:0] p_reg, y_reg;
   logic [15:0] x_reg, xp_reg, yw_reg;
   logic [15:0] yp_reg [4];
   logic [7:0]  c0_reg, c1_reg, c2_reg;
   logic [1:0]  clr_reg;
   logic        lv_reg, mv_reg, we_reg, busy_reg;
   logic [WAIT_W+1:0] stall_reg;
   ctl_state_e  st_reg;

   // ==========================================================
   // Operand selection; each field picks one of two accumulators
   wire [35:0] acc_s  = acc_reg[src_sel];
   wire [35:0] acc_t  = acc_reg[xfer_acc_sel];
   wire [31:0] prod_n = 32'($signed(x_reg) * $signed(y_reg[31:16]));
   wire [35:0] p_ext  = sx32(p_reg);
   wire [35:0] y_ext36 = sx32(y_reg);
   wire go = issue && (st_reg == ST_IDLE);

   // Condition evaluation against the destination accumulator, overflow flags, counters and external flags
   wire [35:0] a_d_now = acc_reg[dst_sel];
   wire f_neg = a_d_now[35];
   wire f_zero = (a_d_now == 36'h0);
   logic cond_ok;
   always_comb begin
      case (condition_code)
         CC_MI:    cond_ok = f_neg;
         CC_PL:    cond_ok = !f_neg;
         CC_EQ:    cond_ok = f_zero;
         CC_NE:    cond_ok = !f_zero;
         CC_GT:    cond_ok = !f_neg && !f_zero;
         CC_LE:    cond_ok = f_neg || f_zero;
         CC_LVS:   cond_ok = lv_reg;
         CC_LVC:   cond_ok = !lv_reg;
         CC_MVS:   cond_ok = mv_reg;
         CC_MVC:   cond_ok = !mv_reg;
         CC_C0GE:  cond_ok = !c0_reg[7];
         CC_C0LT:  cond_ok = c0_reg[7];
         CC_C1GE:  cond_ok = !c1_reg[7];
         CC_C1LT:  cond_ok = c1_reg[7];
         CC_HEADS: cond_ok = ext_flags[XF_HEADS];
         CC_TAILS: cond_ok = !ext_flags[XF_HEADS];
         CC_TRUE:  cond_ok = 1'b1;
         CC_FALSE: cond_ok = 1'b0;
         CC_ALLT:  cond_ok = ext_flags[XF_ALLT];
         CC_ALLF:  cond_ok = !ext_flags[XF_SOMET];
         CC_SOMET: cond_ok = ext_flags[XF_SOMET];
         CC_SOMEF: cond_ok = !ext_flags[XF_ALLT];
         CC_ODDP:  cond_ok = ext_flags[XF_ODDP];
         CC_EVENP: cond_ok = !ext_flags[XF_ODDP];
         CC_MNS1:  cond_ok = ext_flags[XF_MNS1];
         CC_NMNS1: cond_ok = !ext_flags[XF_MNS1];
         CC_NPINT: cond_ok = ext_flags[XF_NPINT];
         CC_NJINT: cond_ok = ext_flags[XF_NJINT];
         CC_LOCK:  cond_ok = ext_flags[XF_LOCK];
         default:  cond_ok = 1'b0;
      endcase
   end

   // Special function enable; false condition suppresses the write
   wire sf_do = go && is_special && (!cond_en || cond_ok);
   wire c0_test = go && is_special && cond_en &&
                  (condition_code == CC_C0GE || condition_code == CC_C0LT);
   wire c1_test = go && is_special && cond_en &&
                  (condition_code == CC_C1GE || condition_code == CC_C1LT);

   // ==========================================================
   // Special function result
   logic [35:0] sf_res;
   logic [31:0] shl_low;
   always_comb begin
      shl_low = 32'h0;
      case (sf_code)
         SF_SHR: begin
            case (shift_sel)
               2'h0: sf_res = 36'($signed(acc_s) >>> 1);
               2'h1: sf_res = 36'($signed(acc_s) >>> 4);
               2'h2: sf_res = 36'($signed(acc_s) >>> 8);
               default: sf_res = 36'($signed(acc_s) >>> 16);
            endcase
         end
         SF_SHL: begin
            case (shift_sel)
               2'h0: shl_low = acc_s[31:0] << 1;
               2'h1: shl_low = acc_s[31:0] << 4;
               2'h2: shl_low = acc_s[31:0] << 8;
               default: shl_low = acc_s[31:0] << 16;
            endcase
            sf_res = sx32(shl_low);
         end
         SF_COPY: sf_res = acc_s;
         SF_NEG:  sf_res = 36'h0 - acc_s;
         SF_INV:  sf_res = ~acc_s;
         SF_RND:  sf_res = (acc_s + 36'h000008000) & 36'hFFFFF0000;
         SF_INCH: sf_res = {acc_s[35:16] + 20'h00001, 16'h0000};
         SF_INC:  sf_res = acc_s + 36'h000000001;
         SF_LD_Y: sf_res = y_ext36;
         SF_LD_P: sf_res = p_ext;
         default: sf_res = acc_s;
      endcase
   end

   // ==========================================================
   // Multiply/ALU function result; product updates only with FN_P_XY, FN_LD_P, FN_ADD_P and FN_SUB_P
   logic [36:0] fn_res;
   logic        fn_wr, fn_p;
   always_comb begin
      fn_wr = 1'b1;
      fn_p  = 1'b0;
      case (func_code)
         FN_P_XY:  begin fn_res = 37'h0; fn_wr = 1'b0; fn_p = 1'b1; end
         FN_LD_P:  begin fn_res = {p_ext[35], p_ext}; fn_p = 1'b1; end
         FN_ADD_P: begin
            fn_res = {acc_s[35], acc_s} + {p_ext[35], p_ext};
            fn_p = 1'b1;
         end
         FN_SUB_P: begin
            fn_res = {acc_s[35], acc_s} - {p_ext[35], p_ext};
            fn_p = 1'b1;
         end
         FN_LD_Y:  fn_res = {y_ext36[35], y_ext36};
         FN_ADD_Y: fn_res = {acc_s[35], acc_s} + {y_ext36[35], y_ext36};
         FN_SUB_Y: fn_res = {acc_s[35], acc_s} - {y_ext36[35], y_ext36};
         FN_AND_Y: fn_res = {1'b0, acc_s & y_ext36};
         FN_OR_Y:  fn_res = {1'b0, acc_s | y_ext36};
         FN_XOR_Y: fn_res = {1'b0, acc_s ^ y_ext36};
         default:  begin fn_res = 37'h0; fn_wr = 1'b0; end
      endcase
   end
   wire fn_do = go && !is_special && fn_wr;
   wire lv_n = fn_res[36] ^ fn_res[35];
   wire mv_n = !((&fn_res[35:31]) || !(|fn_res[35:31]));

   // ==========================================================
   // Transfer decode
   wire tr = go && !is_special && (xfer_code != TR_NONE);
   // A load of x from Y space touches no X pointer
   wire uses_x = (xfer_code == TR_Y_X) || (xfer_code == TR_YA_X) ||
                 (xfer_code == TR_Z_YX);
   wire is_z = (xfer_code == TR_Z_YX) || (xfer_code == TR_Z_Y) ||
               (xfer_code == TR_Z_A);
   wire uses_y = (xfer_code != TR_NONE) && (xfer_code != TR_YA_X);
   wire [15:0] yp_sel = yp_reg[y_ptr_sel];
   wire [15:0] yp_mod = pmod(yp_sel, y_mod_sel, y_incr, 1'b0);
   wire [15:0] yp_z = pmod(yp_mod, y_mod_sel, z_incr, 1'b1);
   wire [15:0] xp_mod = x_inc_sel ? xp_reg + x_incr :
                        xp_reg + 16'h0001;

   // Cycle count from transfer, wait-states and bank conflict
   wire two_cyc = (xfer_code == TR_ST_Y) ||
                  (xfer_code == TR_ST_A) || is_z ||
                  (((xfer_code == TR_Y_X) || (xfer_code == TR_YA_X)) &&
                   !from_cache);
   wire [WAIT_W+1:0] ws = {2'b00, wait_states};
   wire [WAIT_W+1:0] extra =
      (is_special ? (pc_ext ? ws : '0) :
       (((uses_x && x_ext) || (uses_y && y_ext)) ? ws : '0) +
       ((uses_x && uses_y && same_bank && !x_ext && !y_ext) ?
        (WAIT_W+2)'(1) : '0) +
       (two_cyc ? (WAIT_W+2)'(1) : '0));
   // Special functions take one cycle unless fetched externally
   wire stretch = go && (extra != '0);

   // Upper-half load with low-half clear control
   wire [15:0] ld_word = (xfer_code == TR_X_LD) ? x_rdata : y_rdata;
   wire [35:0] a_ld_hi = {{4{ld_word[15]}}, ld_word,
                          clr_reg[xfer_acc_sel] ? acc_t[15:0] : 16'h0000};
   wire [35:0] a_ld_lo = {acc_t[35:16], ld_word};

   // ==========================================================
   // Control registers and sequencing; reset clears clear-low bits
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         clr_reg   <= CLR_RST;
         st_reg    <= ST_IDLE;
         stall_reg <= '0;
         busy_reg  <= 1'b0;
      end else begin
         if (clr_we)
            clr_reg <= clr_wdata;
         case (st_reg)
            ST_IDLE: if (stretch) begin
               st_reg    <= ST_WAIT;
               stall_reg <= extra - (WAIT_W+2)'(1);
               busy_reg  <= 1'b1;
            end
            ST_WAIT: if (stall_reg == '0) begin
               st_reg   <= ST_IDLE;
               busy_reg <= 1'b0;
            end else
               stall_reg <= stall_reg - (WAIT_W+2)'(1);
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   // Counters; any counter test bumps that counter
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         c0_reg <= CNT_RST;
         c1_reg <= CNT_RST;
         c2_reg <= CNT_RST;
      end else begin
         if (c0_test)
            c0_reg <= c0_reg + 8'h01;
         if (c1_test || (go && is_special && event_cnt))
            c1_reg <= c1_reg + 8'h01;
         if (sf_do && event_cnt)
            c2_reg <= c1_reg + 8'h01;
      end
   end

   // Datapath registers; transfer load wins over function result
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         acc_reg[0] <= ACC_RST;
         acc_reg[1] <= ACC_RST;
         p_reg <= 32'h0;
         y_reg <= 32'h0;
         x_reg <= 16'h0;
         xp_reg <= 16'h0;
         yp_reg[0] <= 16'h0;
         yp_reg[1] <= 16'h0;
         yp_reg[2] <= 16'h0;
         yp_reg[3] <= 16'h0;
         lv_reg <= 1'b0;
         mv_reg <= 1'b0;
         we_reg <= 1'b0;
         yw_reg <= 16'h0;
      end else begin
         we_reg <= 1'b0;
         if (sf_do)
            acc_reg[dst_sel] <= sf_res;
         if (fn_do) begin
            acc_reg[dst_sel] <= fn_res[35:0];
            lv_reg <= lv_n;
            mv_reg <= mv_n;
         end
         if (go && !is_special && fn_p)
            p_reg <= prod_n;
         if (tr) begin
            if (uses_x)
               xp_reg <= xp_mod;
            if (uses_y)
               yp_reg[y_ptr_sel] <= is_z ? yp_z : yp_mod;
            case (xfer_code)
               TR_Y_X, TR_Y_LD, TR_Z_YX, TR_Z_Y:
                  if (low_half) y_reg[15:0] <= y_rdata;
                  else y_reg <= {y_rdata, 16'h0000};
               TR_YA_X: y_reg <= acc_t[31:0];
               TR_A_LD, TR_Z_A: acc_reg[xfer_acc_sel] <=
                  low_half ? a_ld_lo : a_ld_hi;
               TR_X_LD: x_reg <= y_rdata;
               default: ;
            endcase
            if (xfer_code == TR_Y_X || xfer_code == TR_YA_X ||
                xfer_code == TR_Z_YX)
               x_reg <= x_rdata;
            if (xfer_code == TR_ST_Y || xfer_code == TR_Z_Y) begin
               we_reg <= 1'b1;
               yw_reg <= low_half ? y_reg[15:0] : y_reg[31:16];
            end
            if (xfer_code == TR_ST_A || xfer_code == TR_Z_A) begin
               we_reg <= 1'b1;
               yw_reg <= low_half ? acc_t[15:0] : acc_t[31:16];
            end
         end
      end
   end

   // ==========================================================
   // Outputs straight from flip-flops
   assign busy = busy_reg;
   assign accumulator_zero = acc_reg[0];
   assign accumulator_one = acc_reg[1];
   assign prod_out = p_reg;
   assign y_out = y_reg;
   assign x_out = x_reg;
   assign x_space_pointer = xp_reg;
   assign y_ptr0 = yp_reg[0];
   assign y_ptr1 = yp_reg[1];
   assign y_ptr2 = yp_reg[2];
   assign y_ptr3 = yp_reg[3];
   assign y_wdata = yw_reg;
   assign y_we = we_reg;
   assign event_counter_first = c1_reg;
   assign event_counter_copy = c2_reg;
   assign counter0 = c0_reg;
   assign clear_low_on_load_bits = clr_reg;
   assign lovf = lv_reg;
   assign movf = mv_reg;

endmodule

// file: test/mac_chk.sv
// Concurrent checks on the datapath ports
`timescale 1ns/1ps
module mac_chk
   import dau_pkg::*;
#(parameter int WAIT_W = 4) (
   input wire logic clk_sys, nrst, issue, busy, is_special, pc_ext,
   input wire logic cond_en, event_cnt, x_inc_sel, dst_sel, src_sel,
   input wire logic [3:0] xfer_code, sf_code,
   input wire logic [4:0] condition_code,
   input wire logic [WAIT_W-1:0] wait_states,
   input wire logic [35:0] accumulator_zero, accumulator_one,
   input wire logic [15:0] x_space_pointer,
   input wire logic [7:0] event_counter_first, event_counter_copy,
   input wire logic [1:0] clear_low_on_load_bits
);
   // Requests made while stretching are ignored
   wire take = issue && !busy;
   wire sf = take && is_special;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   a_reset_clear: assert property (
      $rose(nrst) |-> clear_low_on_load_bits == 2'h0) else $error("clr");
   a_special_one: assert property (
      sf && !pc_ext |=> !busy) else $error("special stretched");
   a_pc_wait: assert property (
      sf && pc_ext && wait_states == 3 |=> busy[*3] ##1 !busy)
      else $error("wait-state count");
   a_event_count: assert property (
      sf && event_cnt |=> event_counter_first == $past(event_counter_first)
      + 8'h01) else $error("first counter");
   a_event_copy: assert property (
      sf && event_cnt && condition_code == CC_TRUE
      |=> event_counter_copy == event_counter_first) else $error("copy");
   a_cond_suppress: assert property (
      sf && cond_en && condition_code == CC_FALSE |=> $stable(
      accumulator_zero) && $stable(accumulator_one)) else $error("not held");
   a_neg_acc: assert property (
      sf && condition_code == CC_TRUE && sf_code == SF_NEG && !dst_sel
      && !src_sel |=> accumulator_zero == 36'h0 - $past(accumulator_zero))
      else $error("negate");
   a_x_post: assert property (
      take && !is_special && xfer_code == TR_Y_X && !x_inc_sel
      |=> x_space_pointer == $past(x_space_pointer) + 16'h1) else $error("x");
   a_no_xfer: assert property (
      take && !is_special && xfer_code == TR_NONE |=> !busy) else $error("b");
endmodule
bind mac_alu_special_functions mac_chk #(.WAIT_W(WAIT_W)) chk_i (.*);

// file: test/opnd_mem.sv
// Operand memory model on the X and Y read ports
`timescale 1ns/1ps
module opnd_mem (
   input  wire logic [15:0] x_addr, // X pointer
   input  wire logic [15:0] y_addr, // Y pointer
   output logic      [15:0] x_data, // X read data
   output logic      [15:0] y_data  // Y read data
);
   // Data follows the address so each distinct address reads a distinct word
   assign x_data = 16'h9000 ^ x_addr;
   assign y_data = 16'hF000 ^ y_addr;
endmodule

// file: test/tb_mac_alu_special_functions.sv
// Self-checking testbench for the multiply/ALU and special datapath
`timescale 1ns/1ps
module tb_mac_alu_special_functions;
   import dau_pkg::*;
   logic clk_sys = 0, nrst = 0, issue = 0, is_special = 0, dst_sel = 0;
   logic src_sel = 0, xfer_acc_sel = 0, low_half = 0, cond_en = 0;
   logic event_cnt = 0, x_inc_sel = 0, from_cache = 0, x_ext = 0, y_ext = 0;
   logic pc_ext = 0, same_bank = 0, clr_we = 0, busy, y_we, lovf, movf;
   logic [3:0] func_code = '0, xfer_code = '0, sf_code = '0, wait_states = '0;
   logic [1:0] shift_sel = '0, y_ptr_sel = '0, y_mod_sel = '0, clr_wdata = '0;
   logic [1:0] clear_low_on_load_bits;
   logic [4:0] condition_code = '0;
   logic [7:0] ext_flags = '0, event_counter_first, event_counter_copy, counter0;
   logic [15:0] x_incr = '0, y_incr = '0, z_incr = '0, x_rdata, y_rdata, x_out;
   logic [15:0] x_space_pointer, y_ptr0, y_ptr1, y_ptr2, y_ptr3, y_wdata;
   logic [31:0] prod_out, y_out;
   logic [35:0] accumulator_zero, accumulator_one;
   int num_errors = 0, checked = 0;
   always #10 clk_sys = ~clk_sys;
   mac_alu_special_functions dut (.*);
   opnd_mem mem (.x_addr(x_space_pointer), .y_addr(y_ptr0),
      .x_data(x_rdata), .y_data(y_rdata));
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic results();
      $display("checked %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Issue one instruction; bounded count of stretch cycles
   task automatic go(input int extra);
      int n;
      n = 0;
      issue = 1;
      @(posedge clk_sys);
      #1 issue = 0;
      while (busy === 1'b1 && n < 20) begin
         n++;
         @(posedge clk_sys);
         #1;
      end
      if (n == 20) begin
         num_errors++;
         results();
      end
      chk(n, extra);
   endtask
   task automatic t_load();
      xfer_code = TR_Y_LD;
      y_mod_sel = 2'h1;
      go(0);
      chk(y_out, 36'hF000_0000);
      chk(y_ptr0, 36'h1);
      xfer_code = TR_NONE;
      is_special = 1;
      sf_code = SF_LD_Y;
      go(0);
      chk(accumulator_zero, 36'hF_F000_0000);
      sf_code = SF_SHR;
      shift_sel = 2'h1;
      dst_sel = 1;
      go(0);
      chk(accumulator_one, 36'hF_FF00_0000);
      sf_code = SF_SHL;
      go(0);
      chk(accumulator_one, 36'h0);
      is_special = 0;
      xfer_code = TR_Y_LD;
      low_half = 1;
      go(0);
      chk(y_out[15:0], 36'hF001);
      $display("t_load done");
   endtask
   task automatic t_cond();
      {low_half, dst_sel, xfer_code, is_special, cond_en} = {6'h00, 2'h3};
      {sf_code, condition_code} = {SF_NEG, CC_FALSE};
      go(0);
      chk(accumulator_zero, 36'hF_F000_0000);
      condition_code = CC_TRUE;
      go(0);
      chk(accumulator_zero, 36'h0_1000_0000);
      {event_cnt, sf_code, condition_code} = {1'b1, SF_INC, CC_FALSE};
      go(0);
      chk({event_counter_first, event_counter_copy}, 36'h0100);
      condition_code = CC_TRUE;
      go(0);
      chk({event_counter_first, event_counter_copy}, 36'h0202);
      chk(accumulator_zero, 36'h0_1000_0001);
      $display("t_cond done");
   endtask
   task automatic t_wait();
      {cond_en, event_cnt, pc_ext, wait_states, sf_code} = {7'h13, SF_COPY};
      go(3);
      {pc_ext, is_special, xfer_code} = {2'h0, TR_Y_X};
      {from_cache, same_bank} = 2'h3;
      go(1);
      chk(x_space_pointer, 36'h1);
      {from_cache, same_bank, x_ext} = 3'h1;
      go(4);
      chk(x_out, 36'h9001);
      $display("t_wait done");
   endtask
   task automatic t_alu();
      {is_special, x_ext, xfer_code, func_code} = {2'h0, TR_NONE, FN_P_XY};
      go(0);
      chk(prod_out, 36'h06FE_A003);
      {clr_we, clr_wdata, dst_sel, func_code} = {4'hB, FN_ADD_P};
      go(0);
      chk(accumulator_one, 36'h0_16FE_A004);
      chk({lovf, movf}, 36'h0);
      {clr_we, xfer_code, func_code} = {1'b0, TR_A_LD, FN_NONE};
      go(0);
      chk(accumulator_zero, 36'hF_F004_0001);
      xfer_acc_sel = 1;
      go(0);
      chk(accumulator_one, 36'hF_F005_0000);
      {is_special, cond_en, condition_code, sf_code} = {2'h3, CC_C0GE, SF_RND};
      go(0);
      chk(accumulator_one, 36'hF_F004_0000);
      chk(counter0, 36'h1);
      $display("t_alu done");
   endtask
   initial begin
      repeat (3) @(posedge clk_sys);
      #1 nrst = 1;
      chk(clear_low_on_load_bits, 36'h0);
      t_load();
      t_cond();
      t_wait();
      t_alu();
      results();
   end
endmodule
